/* File: include/rsc_pkg.sv */
// package for the reference switchover control block: register map, fields, states, timing
// assumes an avalon-mm slave with 32-bit data and word-aligned byte addresses
// Summary of operation
// - redundancy enable bit 0 selects manual switching, 1 selects automatic redundancy.
// - at most one automatic switchover per device reset, initial to alternate.
// - automatic mode switches to alternate when monitor reports active frequency out of window.
// - after automatic switchover the alternate stays active until reset, whatever its accuracy.
// - initial automatic reference is the select pin level when redundancy enable is set.
// - manual request comes from pin when soft enable is 0, from soft bit when 1.
// - request 0 makes primary active, request 1 makes secondary active.
// - in manual mode the monitor out-of-window result never changes reference.
// - with smooth switching enabled, the change waits for minimal phase offset.
// - with smooth switching disabled, the change is immediate.
// - active reference pin and status bit read 0 for primary, 1 for secondary.
// - switch-in-progress rises when request changes and falls when the switch completes.
// - request changes during a smooth switch in progress are ignored.
// - if either reference is absent, the smooth switch stalls and keeps current reference.
// - with smooth switching enabled, if requested reference failed, keep current and complete when it returns.
// - a stalled pending switch is cancelled only by device reset.
// - loss of reference reads 1 when no clock or below about 1 MHz, else 0.
// - monitor in/out-of-window result is the automatic switchover trigger.
package rsc_pkg;
  // printed offsets are not multiples of four, so byte address = 4 * index
  localparam logic [11:0] RSC_IDX_CTRL    = 12'h082;
  localparam logic [11:0] RSC_IDX_STATUS  = 12'h021;
  localparam int          RSC_ADDR_W      = 14;
  localparam logic [13:0] RSC_ADDR_CTRL   = {RSC_IDX_CTRL, 2'b00};
  localparam logic [13:0] RSC_ADDR_STATUS = {RSC_IDX_STATUS, 2'b00};
  localparam logic [7:0]  RSC_CTRL_RESET  = 8'h00;
  localparam logic [31:0] RSC_UNMAPPED    = 32'h00000000;
  // control field positions
  localparam int RSC_B_SOFT_SEL    = 0;
  localparam int RSC_B_SOFT_EN     = 1;
  localparam int RSC_B_REDUND_EN   = 2;
  localparam int RSC_B_NO_SMOOTH   = 3;
  // status field positions
  localparam int RSC_B_LOR_PRI     = 0;
  localparam int RSC_B_LOR_SEC     = 1;
  localparam int RSC_B_ACTIVE      = 3;
  localparam int RSC_B_IN_PROGRESS = 6;
  localparam int RSC_B_AUTO_DONE   = 7;
  // one wait state on every access
  localparam int RSC_WAIT_CYCLES   = 1;
  typedef enum logic [3:0] {
    RSC_IDLE  = 4'b0001,
    RSC_WAIT  = 4'b0010,
    RSC_SWAP  = 4'b0100,
    RSC_DONE  = 4'b1000
  } rsc_state_t;
endpackage

/* File: rtl/rsc_sync.sv */
// two-flop synchroniser for a single level
// assumes the input may change at any time relative to ref_clk
`timescale 1ns/1ps
module rsc_sync (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;

  // the first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

/* File: rtl/rsc_top.sv */
// reference switchover control: manual and single-shot automatic selection of the synthesizer reference
// assumes lor and monitor inputs are synchronous to ref_clk; avalon-mm slave with waitrequest
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic [RSC_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  reference_select,
  input  wire logic                  loss_of_reference_primary,
  input  wire logic                  loss_of_reference_secondary,
  input  wire logic                  monitor_out_of_window,
  input  wire logic                  phase_offset_minimal,
  output logic                       active_reference_indicator,
  output logic                       switch_in_progress_indicator
);
  logic [7:0]  reference_switch_control;
  logic        sel_sync;
  logic        wait_done;
  logic        initial_ref;
  logic        auto_done;
  logic        pending_target;
  logic        request;
  logic        redund_prev;
  logic        next_active;
  rsc_state_t  state;

  wire ctrl_soft_sel  = reference_switch_control[RSC_B_SOFT_SEL];
  wire ctrl_soft_en   = reference_switch_control[RSC_B_SOFT_EN];
  wire ctrl_redund_en = reference_switch_control[RSC_B_REDUND_EN];
  wire ctrl_no_smooth = reference_switch_control[RSC_B_NO_SMOOTH];

  rsc_sync u_sel_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (reference_select),
    .sync_out (sel_sync)
  );

  // ---------------- avalon-mm slave ----------------
  wire access  = avs_read | avs_write;
  wire hit_ctl = (avs_address == RSC_ADDR_CTRL);
  wire hit_sts = (avs_address == RSC_ADDR_STATUS);
  wire commit  = access & wait_done;

  assign avs_waitrequest = access & ~wait_done;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_done <= 1'b0;
    end else begin
      wait_done <= access & ~wait_done;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reference_switch_control <= RSC_CTRL_RESET;
    end else if (commit && avs_write && hit_ctl && avs_byteenable[0]) begin
      reference_switch_control <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      avs_readdata <= RSC_UNMAPPED;
    end else if (access && !wait_done && avs_read) begin
      if (hit_ctl) begin
        avs_readdata <= {24'h000000, reference_switch_control};
      end else if (hit_sts) begin
        avs_readdata <= RSC_UNMAPPED;
        avs_readdata[RSC_B_LOR_PRI]     <= loss_of_reference_primary;
        avs_readdata[RSC_B_LOR_SEC]     <= loss_of_reference_secondary;
        avs_readdata[RSC_B_ACTIVE]      <= active_reference_indicator;
        avs_readdata[RSC_B_IN_PROGRESS] <= switch_in_progress_indicator;
        avs_readdata[RSC_B_AUTO_DONE]   <= auto_done;
      end else begin
        avs_readdata <= RSC_UNMAPPED;
      end
    end
  end

  // ---------------- request source ----------------
  // capture the initial reference on the rising edge of the redundancy enable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      redund_prev <= 1'b0;
      initial_ref <= 1'b0;
    end else begin
      redund_prev <= ctrl_redund_en;
      if (ctrl_redund_en && !redund_prev) begin
        initial_ref <= sel_sync;
      end
    end
  end

  // single shot: once taken, auto_done holds until reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      auto_done <= 1'b0;
    end else if (ctrl_redund_en && redund_prev && !auto_done
                 && monitor_out_of_window && state == RSC_IDLE
                 && active_reference_indicator == initial_ref) begin
      auto_done <= 1'b1;
    end
  end

  always_comb begin
    if (ctrl_redund_en) begin
      request = auto_done ? ~initial_ref : initial_ref;
    end else if (ctrl_soft_en) begin
      request = ctrl_soft_sel;
    end else begin
      request = sel_sync;
    end
  end

  // ---------------- switchover state machine ----------------
  wire request_change = (request != active_reference_indicator);
  wire either_absent  = loss_of_reference_primary | loss_of_reference_secondary;

  always_comb begin
    next_active = active_reference_indicator;
    if (state == RSC_SWAP) begin
      next_active = pending_target;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state          <= RSC_IDLE;
      pending_target <= 1'b0;
    end else begin
      case (state)
        RSC_IDLE: begin
          if (request_change) begin
            pending_target <= request;
            state          <= ctrl_no_smooth ? RSC_SWAP : RSC_WAIT;
          end
        end
        RSC_WAIT: begin
          // later request edges are dropped here; only reset clears a stall
          if (!either_absent && phase_offset_minimal) begin
            state <= RSC_SWAP;
          end
        end
        RSC_SWAP: begin
          state <= RSC_DONE;
        end
        RSC_DONE: begin
          state <= RSC_IDLE;
        end
        default: begin
          state <= RSC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      active_reference_indicator <= 1'b0;
    end else begin
      active_reference_indicator <= next_active;
    end
  end

  // in progress from request capture until the return to idle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      switch_in_progress_indicator <= 1'b0;
    end else if (state == RSC_IDLE) begin
      switch_in_progress_indicator <= request_change;
    end else if (state == RSC_DONE) begin
      switch_in_progress_indicator <= 1'b0;
    end
  end
endmodule

/* File: testbench/rsc_board.sv */
// board-side model driving the reference select pin
// assumes the bench sets the wanted level; the pin moves only after a rising edge
`timescale 1ns/1ps
module rsc_board (
  input  wire logic ref_clk,
  input  wire logic want_sec,
  output logic      reference_select
);
  initial reference_select = 1'b0;
  // held static between requests, so auto mode sees a fixed level
  always @(posedge ref_clk) begin
    reference_select <= want_sec;
  end
endmodule

/* File: testbench/rsc_top_properties.sv */
// port checker for the switchover block
// assumes control writes are seen on the avalon ports
`timescale 1ns/1ps
module rsc_top_properties
  import rsc_pkg::*;
(
  input logic                  ref_clk,
  input logic                  sys_rst,
  input logic [RSC_ADDR_W-1:0] avs_address,
  input logic                  avs_write,
  input logic [31:0]           avs_writedata,
  input logic [3:0]            avs_byteenable,
  input logic                  avs_waitrequest,
  input logic                  reference_select,
  input logic                  loss_of_reference_secondary,
  input logic                  phase_offset_minimal,
  input logic                  active_reference_indicator,
  input logic                  switch_in_progress_indicator
);
  logic [3:0] ctrl_q;
  logic       auto_sw;
  logic       act;
  logic       sip;
  assign act = active_reference_indicator;
  assign sip = switch_in_progress_indicator;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) ctrl_q <= 4'h0;
    else if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == RSC_ADDR_CTRL) begin
      ctrl_q <= avs_writedata[3:0];
    end
  end
  // a change seen once in redundancy mode marks the single shot as used
  always_ff @(posedge ref_clk) begin
    if (sys_rst) auto_sw <= 1'b0;
    else auto_sw <= auto_sw | (ctrl_q[2] & $changed(act));
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  switch_gated_a: assert property ($changed(act) |-> $past(sip))
    else $error("active changed outside a switch");
  smooth_wait_a: assert property (!ctrl_q[3] && $changed(act) |->
    $past(phase_offset_minimal, 2) && !$past(loss_of_reference_secondary, 2)) else $error("smooth switch too early");
  done_drop_a: assert property ($changed(act) |=> $fell(sip)) else $error("progress not cleared");
  fast_switch_a: assert property (ctrl_q[3] && $rose(sip) |=> $changed(act)) else $error("switch not immediate");
  soft_match_a: assert property ((!sip && ctrl_q[2:1] == 2'b01 && $stable(ctrl_q)) [*4] |-> act == ctrl_q[0])
    else $error("active differs from soft select");
  pin_match_a: assert property ((!sip && ctrl_q[2:1] == 2'b00 && $stable(ctrl_q) && $stable(reference_select)) [*8] |->
    act == reference_select) else $error("active differs from pin");
  monitor_ignored_a: assert property (!ctrl_q[2] && ctrl_q[1] && ctrl_q[0] == act && !sip |=> !sip)
    else $error("switch without request");
  single_shot_a: assert property (auto_sw && ctrl_q[2] |-> $stable(act)) else $error("second auto switch");
  cover property ($rose(sip));
  cover property (ctrl_q[2] && $changed(act));
  cover property ((loss_of_reference_secondary && sip) [*4]);
endmodule
bind rsc_top rsc_top_properties i_rsc_top_properties (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .reference_select(reference_select),
  .loss_of_reference_secondary(loss_of_reference_secondary), .phase_offset_minimal(phase_offset_minimal),
  .active_reference_indicator(active_reference_indicator),
  .switch_in_progress_indicator(switch_in_progress_indicator));

/* File: testbench/tb_rsc_top.sv */
// self-checking bench for the switchover block
// assumes one wait state per bus access, as the slave answers
`timescale 1ns/1ps
module tb_rsc_top
  import rsc_pkg::*;
;
  logic        ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, want_sec, ref_sel;
  logic        lor_p, lor_s, mon, phase, act, sip;
  logic [13:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  int          miscompares, total_checks;
  rsc_board i_rsc_board (.ref_clk(ref_clk), .want_sec(want_sec), .reference_select(ref_sel));
  rsc_top i_rsc_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reference_select(ref_sel), .loss_of_reference_primary(lor_p),
    .loss_of_reference_secondary(lor_s), .monitor_out_of_window(mon), .phase_offset_minimal(phase),
    .active_reference_indicator(act), .switch_in_progress_indicator(sip));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [13:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    // look at waitrequest while it is settled, then take the answer on the edge that completes the access
    do @(negedge ref_clk); while (avs_waitrequest !== 1'b0);
    @(posedge ref_clk);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // a pin request needs the board edge, two sync flops and the idle compare before progress rises
  task settle;
    repeat (8) @(posedge ref_clk);
    while (sip !== 1'b0) @(posedge ref_clk);
  endtask
  task s_reset;
    bus(0, RSC_ADDR_CTRL, 8'h00);
    check(rdata, {24'h000000, RSC_CTRL_RESET});
    lor_p <= 1'b1;
    bus(0, RSC_ADDR_STATUS, 8'h00);
    check(rdata, 32'h00000001);
    lor_p <= 1'b0;
    bus(0, 14'h0010, 8'h00);
    check(rdata, RSC_UNMAPPED);
  endtask
  task s_soft;
    bus(1, RSC_ADDR_CTRL, 8'h0B);
    settle;
    check(act, 1'b1);
    bus(0, RSC_ADDR_STATUS, 8'h00);
    check(rdata, 32'h00000008);
    bus(1, RSC_ADDR_CTRL, 8'h0A);
    settle;
    check(act, 1'b0);
  endtask
  task s_smooth;
    lor_s <= 1'b1;
    bus(1, RSC_ADDR_CTRL, 8'h03);
    repeat (10) @(posedge ref_clk);
    check(sip, 1'b1);
    check(act, 1'b0);
    phase <= 1'b1;
    bus(0, RSC_ADDR_STATUS, 8'h00);
    check(rdata, 32'h00000042);
    lor_s <= 1'b0;
    settle;
    check(act, 1'b1);
    phase <= 1'b0;
  endtask
  task s_pin;
    bus(1, RSC_ADDR_CTRL, 8'h08);
    settle;
    check(act, 1'b0);
    want_sec <= 1'b1;
    mon <= 1'b1;
    settle;
    check(act, 1'b1);
    repeat (10) @(posedge ref_clk);
    check(act, 1'b1);
    mon <= 1'b0;
    want_sec <= 1'b0;
    settle;
  endtask
  task s_auto;
    bus(1, RSC_ADDR_CTRL, 8'h0C);
    repeat (8) @(posedge ref_clk);
    check(act, 1'b0);
    mon <= 1'b1;
    settle;
    check(act, 1'b1);
    bus(0, RSC_ADDR_STATUS, 8'h00);
    check(rdata, 32'h00000088);
    mon <= 1'b0;
    repeat (4) @(posedge ref_clk);
    mon <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check(act, 1'b1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    mon <= 1'b0;
    @(posedge ref_clk);
    check(act, 1'b0);
  endtask
  initial begin
    #20000;
    miscompares++;
    summarize;
  end
  initial begin
    {sys_rst, avs_read, avs_write, want_sec, lor_p, lor_s, mon, phase} = 8'h80;
    avs_address = 14'h0000;
    avs_writedata = 32'h00000000;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    s_reset;
    s_soft;
    s_smooth;
    s_pin;
    s_auto;
    summarize;
  end
endmodule
